// ### test_zdofb_top.sv
// Self-checking bench for the device-object frame builder
`timescale 1ns/1ps
module test_zdofb_top;
   logic                  core_clk, arst_n, rx_valid, req_valid, status_req, csum_error;
   logic                  receiver_addressing_option, rsp_valid, rsp_ready, stall_en;
   logic                  pay_valid, pay_ready, tx_valid, tx_ready;
   logic [7:0]            rx_data, pay_data, tx_data;
   zdofb_pkg::zdofb_req_s req;
   zdofb_pkg::zdofb_rsp_s rsp;
   int                    bad_count, checked, n_req, n_stat, n_err;
   logic [7:0]            pq[$];
   logic [7:0]            exp[$];

   zdofb_top u_zdofb_top (
      .core_clk(core_clk), .arst_n(arst_n), .rx_valid(rx_valid), .rx_data(rx_data),
      .req(req), .req_valid(req_valid), .status_req(status_req), .csum_error(csum_error),
      .receiver_addressing_option(receiver_addressing_option), .rsp(rsp),
      .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .pay_data(pay_data),
      .pay_valid(pay_valid), .pay_ready(pay_ready), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready));
   zdofb_host_model u_zdofb_host_model (
      .core_clk(core_clk), .arst_n(arst_n), .stall_en(stall_en), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // ----------------------------------------------------------------
   // Monitors and payload source
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      n_req  += (req_valid === 1'b1);
      n_stat += (status_req === 1'b1);
      n_err  += (csum_error === 1'b1);
   end
   initial forever begin
      @(posedge core_clk);
      if (pay_valid && pay_ready === 1'b1) void'(pq.pop_front());
      #2 pay_valid = (pq.size() != 0);
      pay_data = pay_valid ? pq[0] : ~pay_data;
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic cmp(input logic [63:0] g, input logic [63:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
      end
   endtask
   task automatic put(input logic [7:0] b);
      @(posedge core_clk);
      #2 rx_valid = 1'b1;
      rx_data = b;
   endtask
   task automatic send(input logic [7:0] fid, input logic [63:0] d64, input logic [15:0] d16,
                       input logic [15:0] cl, input logic [7:0] seq, input logic [7:0] x[$],
                       input logic bad);
      logic [167:0] h;
      logic [7:0]   b[$];
      logic [7:0]   s;
      h = {8'h11, fid, d64, d16, 16'h0000, cl, 16'h0000, 16'h0000, seq};
      for (int i = 20; i >= 0; i--) b.push_back(h[i*8 +: 8]);
      b = {b, x};
      s = 8'h00;
      n_req = 0;
      n_stat = 0;
      n_err = 0;
      put(zdofb_pkg::DELIM);
      put(8'h00);
      put(8'(b.size()));
      foreach (b[i]) begin
         put(b[i]);
         s += b[i];
      end
      put(8'hFF - s - {7'h00, bad});
      @(posedge core_clk);
      #2 rx_valid = 1'b0;
      rx_data = ~rx_data;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic offer;
      int k;
      @(posedge core_clk);
      #2 rsp_valid = 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (rsp_ready !== 1'b1 && k < 200);
      cmp(rsp_ready, 1'b1);
      #2 rsp_valid = 1'b0;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_lqi;
      send(8'h01, 64'h0013A20040401234, 16'hFFFE, zdofb_pkg::CL_NBR_REQ,
           8'h76, '{8'h07}, 1'b0);
      cmp(n_req, 1);
      cmp(n_stat, 1);
      cmp(req.frame_id, 8'h01);
      cmp(req.cluster, zdofb_pkg::CL_NBR_REQ);
      cmp(req.zdo, 1);
      cmp(req.seq, 8'h76);
      cmp(req.start_index, 8'h07);
   endtask
   task automatic t_addr;
      send(8'h00, 64'h000000000000FFFF, 16'hFFFE, zdofb_pkg::CL_ADDR_REQ, 8'h44,
           '{8'h34, 8'h12, 8'h40, 8'h40, 8'h00, 8'hA2, 8'h13, 8'h00, 8'h02, 8'h05}, 1'b0);
      cmp(n_stat, 0);
      cmp(req.target64, 64'h0013A20040401234);
      cmp({req.req_type, req.start_index, req.seq}, 24'h020544);
   endtask
   task automatic t_bad;
      put(8'h55);
      put(zdofb_pkg::DELIM);
      put(8'h00);
      put(8'h00);
      send(8'h01, 64'h0, 16'h0000, zdofb_pkg::CL_ACT_EP_REQ, 8'h10, '{8'h00}, 1'b1);
      cmp({n_err, n_req}, {32'd1, 32'd0});
      cmp(req.cluster, zdofb_pkg::CL_ADDR_REQ);
      send(8'h02, 64'h1, 16'h1234, zdofb_pkg::CL_ROUTE_REQ, 8'h20, '{8'h03}, 1'b0);
      cmp(n_req, 1);
      cmp(req.cluster, zdofb_pkg::CL_ROUTE_REQ);
   endtask
   task automatic t_rsp(input logic [15:0] cl, input int n);
      logic [7:0] s;
      #2 receiver_addressing_option = 1'b1;
      stall_en = (n > 0);
      rsp = '{64'h0013A20040401234, 16'h5A3C, 8'h00, 8'h00, cl, 16'h0000,
              8'h01, 8'h76, 8'(n)};
      for (int k = 0; k < n; k++) pq.push_back(8'hA0 + 8'(k));
      exp = '{zdofb_pkg::DELIM, 8'h00, 8'(19 + n), zdofb_pkg::API_EXPL_RX};
      for (int k = 18; k >= 1; k--) exp.push_back(rsp[k*8 +: 8]);
      exp = {exp, pq};
      s = 8'h00;
      for (int k = 3; k < exp.size(); k++) s += exp[k];
      exp.push_back(8'hFF - s);
      u_zdofb_host_model.got.delete();
      offer();
      for (int k = 0; k < 400 && u_zdofb_host_model.got.size() < exp.size(); k++)
         @(posedge core_clk);
      cmp(u_zdofb_host_model.got.size(), exp.size());
      foreach (exp[i]) cmp(u_zdofb_host_model.got[i], exp[i]);
   endtask
   task automatic t_noao;
      #2 receiver_addressing_option = 1'b0;
      rsp.cluster = zdofb_pkg::CL_ADDR_RSP;
      rsp.pay_len = 8'h02;
      pq = '{8'h11, 8'h22};
      u_zdofb_host_model.got.delete();
      offer();
      repeat (60) @(posedge core_clk);
      cmp({u_zdofb_host_model.got.size(), pq.size()}, {32'd0, 32'd2});
      pq.delete();
   endtask
   task automatic print_verdict;
      if (bad_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      {arst_n, rx_valid, rx_data, receiver_addressing_option, rsp_valid} = '0;
      {pay_data, pay_valid, stall_en, rsp} = '0;
      bad_count = 0;
      checked = 0;
      repeat (3) @(posedge core_clk);
      #2 arst_n = 1'b1;
      t_lqi();
      t_addr();
      t_bad();
      t_rsp(zdofb_pkg::CL_NBR_RSP, 3);
      t_rsp(zdofb_pkg::CL_ROUTE_RSP, 0);
      t_noao();
      print_verdict();
   end
   initial begin
      #500000;
      bad_count++;
      print_verdict();
   end
endmodule

// ### zdofb_assertions.sv
// Concurrent checks on the frame builder ports
`timescale 1ns/1ps
module zdofb_assertions (
   input wire logic                  core_clk,
   input wire logic                  arst_n,
   input wire zdofb_pkg::zdofb_req_s req,
   input wire logic                  req_valid,
   input wire logic                  status_req,
   input wire logic                  csum_error,
   input wire logic                  receiver_addressing_option,
   input wire logic                  rsp_valid,
   input wire logic                  rsp_ready,
   input wire logic                  pay_ready,
   input wire logic [7:0]            tx_data,
   input wire logic                  tx_valid,
   input wire logic                  tx_ready
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------------------------------
   // Parser
   // ----------------------------------------------------------------
   status_pair_a: assert property (req_valid |-> status_req == (req.frame_id != 8'h00))
      else $error("status pulse disagrees with frame id");
   status_only_a: assert property (status_req |-> req_valid)
      else $error("status pulse without a good frame");
   req_spacing_a: assert property (req_valid |=> !req_valid [*4])
      else $error("good frames closer than the shortest frame");
   req_hold_a: assert property (!req_valid |-> $stable(req))
      else $error("captured request changed without a good frame");
   err_excl_a: assert property (csum_error |-> !req_valid && !status_req)
      else $error("bad checksum frame was still reported good");
   // ----------------------------------------------------------------
   // Builder
   // ----------------------------------------------------------------
   delim_first_a: assert property (rsp_valid && rsp_ready && receiver_addressing_option
      |-> ##[1:4] (tx_valid && tx_data == zdofb_pkg::DELIM))
      else $error("response frame did not open with the delimiter");
   tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("stalled byte dropped or changed");
   busy_a: assert property (rsp_valid && rsp_ready && receiver_addressing_option |=> !rsp_ready)
      else $error("second response taken during a frame");
   pay_gap_a: assert property (pay_ready |=> !pay_ready)
      else $error("payload requested on consecutive cycles");
   no_frame_a: assert property (rsp_valid && rsp_ready && !receiver_addressing_option
      |=> !pay_ready [*4])
      else $error("payload drawn while responses are withheld");
   good_c: cover property (req_valid && status_req);
   bad_c: cover property (csum_error);
   stall_c: cover property (tx_valid && !tx_ready);
   pay_c: cover property (pay_ready);
endmodule

bind zdofb_top zdofb_assertions u_zdofb_assertions (
   .core_clk(core_clk), .arst_n(arst_n), .req(req), .req_valid(req_valid),
   .status_req(status_req), .csum_error(csum_error),
   .receiver_addressing_option(receiver_addressing_option), .rsp_valid(rsp_valid),
   .rsp_ready(rsp_ready), .pay_ready(pay_ready), .tx_data(tx_data), .tx_valid(tx_valid),
   .tx_ready(tx_ready)
);

// ### zdofb_host_model.sv
// Host side byte sink for the outgoing frame stream
`timescale 1ns/1ps
module zdofb_host_model (
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic       stall_en,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output      logic       tx_ready
);
   logic [7:0] got[$];
   logic [1:0] phase;
   // Stalls one cycle in four so the spare buffer entry fills
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase    <= 2'h0;
         tx_ready <= 1'b0;
      end else begin
         phase    <= phase + 2'h1;
         tx_ready <= !(stall_en && phase == 2'h2);
      end
   end
   // Bytes kept whole; framing is judged by the bench
   always @(posedge core_clk) begin
      if (arst_n && tx_valid && tx_ready) begin
         got.push_back(tx_data);
      end
   end
endmodule

// ### zdofb_pkg.sv
// Shared constants and carriers for the device-object frame builder
package zdofb_pkg;

   // ----------------------------------------------------------------
   // Frame constants
   // ----------------------------------------------------------------
   localparam logic [7:0]  DELIM          = 8'h7E;
   localparam logic [7:0]  CSUM_BASE      = 8'hFF;
   localparam logic [7:0]  API_EXPL_TX    = 8'h11;
   localparam logic [7:0]  API_EXPL_RX    = 8'h91;
   localparam logic [15:0] EXPL_RX_FIXED  = 16'h0013;  // API id up to and incl. sequence byte
   localparam logic [15:0] CL_ADDR_REQ    = 16'h0000;
   localparam logic [15:0] CL_ACT_EP_REQ  = 16'h0005;
   localparam logic [15:0] CL_NBR_REQ     = 16'h0031;
   localparam logic [15:0] CL_ROUTE_REQ   = 16'h0032;
   localparam logic [15:0] CL_ADDR_RSP    = 16'h8000;
   localparam logic [15:0] CL_NBR_RSP     = 16'h8031;
   localparam logic [15:0] CL_ROUTE_RSP   = 16'h8032;

   // ----------------------------------------------------------------
   // Body byte positions of an explicit transmit frame (API id = 0)
   // ----------------------------------------------------------------
   localparam logic [7:0]  TX_POS_FID     = 8'h01;
   localparam logic [7:0]  TX_POS_SEP     = 8'h0C;
   localparam logic [7:0]  TX_POS_DEP     = 8'h0D;
   localparam logic [7:0]  TX_POS_CL_HI   = 8'h0E;
   localparam logic [7:0]  TX_POS_CL_LO   = 8'h0F;
   localparam logic [7:0]  TX_POS_PR_HI   = 8'h10;
   localparam logic [7:0]  TX_POS_PR_LO   = 8'h11;
   localparam logic [7:0]  TX_POS_SEQ     = 8'h14;
   localparam logic [7:0]  TX_POS_ADDR0   = 8'h15;
   localparam logic [7:0]  TX_POS_ADDR7   = 8'h1C;
   localparam logic [7:0]  TX_POS_RTYPE   = 8'h1D;
   localparam logic [7:0]  TX_POS_START   = 8'h1E;

   // ----------------------------------------------------------------
   // Byte positions of an outgoing explicit receive frame
   // ----------------------------------------------------------------
   localparam logic [4:0]  RX_POS_API     = 5'h03;
   localparam logic [4:0]  RX_POS_SEQ     = 5'h15;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [63:0] src_addr64;
      logic [15:0] src_addr16;
      logic [7:0]  src_ep;
      logic [7:0]  dst_ep;
      logic [15:0] cluster;
      logic [15:0] profile;
      logic [7:0]  rx_opts;
      logic [7:0]  seq;
      logic [7:0]  pay_len;
   } zdofb_rsp_s;

   typedef struct packed {
      logic [7:0]  frame_id;
      logic [15:0] cluster;
      logic        zdo;
      logic [7:0]  seq;
      logic [63:0] target64;
      logic [7:0]  req_type;
      logic [7:0]  start_index;
   } zdofb_req_s;

   typedef enum logic [4:0] {
      P_HUNT  = 5'b00001,
      P_LENHI = 5'b00010,
      P_LENLO = 5'b00100,
      P_BODY  = 5'b01000,
      P_CSUM  = 5'b10000
   } zdofb_pst_e;

   typedef enum logic [3:0] {
      B_IDLE = 4'b0001,
      B_HDR  = 4'b0010,
      B_PAY  = 4'b0100,
      B_CSUM = 4'b1000
   } zdofb_bst_e;

endpackage

// ### zdofb_top.sv
// Device-side explicit frame parser and explicit receive frame builder
`timescale 1ns/1ps
module zdofb_top (
   input  wire logic               core_clk,
   input  wire logic               arst_n,
   input  wire logic               rx_valid,
   input  wire logic [7:0]         rx_data,
   output      zdofb_pkg::zdofb_req_s req,
   output      logic               req_valid,
   output      logic               status_req,
   output      logic               csum_error,
   input  wire logic               receiver_addressing_option,
   input  wire zdofb_pkg::zdofb_rsp_s rsp,
   input  wire logic               rsp_valid,
   output      logic               rsp_ready,
   input  wire logic [7:0]         pay_data,
   input  wire logic               pay_valid,
   output      logic               pay_ready,
   output      logic [7:0]         tx_data,
   output      logic               tx_valid,
   input  wire logic               tx_ready
);

   // ----------------------------------------------------------------
   // Incoming frame parser
   // ----------------------------------------------------------------
   zdofb_pkg::zdofb_pst_e pst;
   logic [15:0]           plen;
   logic [15:0]           pidx;
   logic [7:0]            psum;
   logic [7:0]            papi;
   zdofb_pkg::zdofb_req_s pcap;
   logic [7:0]            psep;
   logic [7:0]            pdep;
   logic [15:0]           pprof;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pst  <= zdofb_pkg::P_HUNT;
         plen <= 16'h0000;
         pidx <= 16'h0000;
      end else if (rx_valid) begin
         case (pst)
            zdofb_pkg::P_HUNT: begin
               if (rx_data == zdofb_pkg::DELIM) pst <= zdofb_pkg::P_LENHI;
            end
            zdofb_pkg::P_LENHI: begin
               plen[15:8] <= rx_data;
               pst        <= zdofb_pkg::P_LENLO;
            end
            zdofb_pkg::P_LENLO: begin
               plen[7:0] <= rx_data;
               pidx      <= 16'h0000;
               // Empty frames carry no API id; treat as noise and resync
               pst <= ({plen[15:8], rx_data} == 16'h0000) ? zdofb_pkg::P_HUNT
                                                           : zdofb_pkg::P_BODY;
            end
            zdofb_pkg::P_BODY: begin
               pidx <= pidx + 16'h0001;
               if (pidx + 16'h0001 == plen) pst <= zdofb_pkg::P_CSUM;
            end
            zdofb_pkg::P_CSUM: pst <= zdofb_pkg::P_HUNT;
            default: pst <= zdofb_pkg::P_HUNT;
         endcase
      end
   end

   // Running sum over body bytes, checked against the trailing byte
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         psum <= 8'h00;
      end else if (rx_valid) begin
         if (pst == zdofb_pkg::P_LENLO) psum <= 8'h00;
         else if (pst == zdofb_pkg::P_BODY) psum <= psum + rx_data;
      end
   end

   // Field capture by body position; long address arrives low byte first
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         papi  <= 8'h00;
         pcap  <= '0;
         psep  <= 8'h00;
         pdep  <= 8'h00;
         pprof <= 16'h0000;
      end else if (rx_valid && pst == zdofb_pkg::P_LENLO) begin
         pcap <= '0;
      end else if (rx_valid && pst == zdofb_pkg::P_BODY && pidx[15:8] == 8'h00) begin
         if (pidx[7:0] == 8'h00) papi <= rx_data;
         if (pidx[7:0] == zdofb_pkg::TX_POS_FID) pcap.frame_id <= rx_data;
         if (pidx[7:0] == zdofb_pkg::TX_POS_SEP) psep <= rx_data;
         if (pidx[7:0] == zdofb_pkg::TX_POS_DEP) pdep <= rx_data;
         if (pidx[7:0] == zdofb_pkg::TX_POS_CL_HI) pcap.cluster[15:8] <= rx_data;
         if (pidx[7:0] == zdofb_pkg::TX_POS_CL_LO) pcap.cluster[7:0] <= rx_data;
         if (pidx[7:0] == zdofb_pkg::TX_POS_PR_HI) pprof[15:8] <= rx_data;
         if (pidx[7:0] == zdofb_pkg::TX_POS_PR_LO) pprof[7:0] <= rx_data;
         if (pidx[7:0] == zdofb_pkg::TX_POS_SEQ) pcap.seq <= rx_data;
         if (pidx[7:0] >= zdofb_pkg::TX_POS_ADDR0 && pidx[7:0] <= zdofb_pkg::TX_POS_ADDR7)
            pcap.target64 <= {rx_data, pcap.target64[63:8]};
         if (pcap.cluster == zdofb_pkg::CL_ADDR_REQ) begin
            if (pidx[7:0] == zdofb_pkg::TX_POS_RTYPE) pcap.req_type <= rx_data;
            if (pidx[7:0] == zdofb_pkg::TX_POS_START) pcap.start_index <= rx_data;
         end else if (pidx[7:0] == zdofb_pkg::TX_POS_ADDR0) begin
            pcap.start_index <= rx_data;
         end
      end
   end

   // Checked frame hand-off; a bad sum only raises a one-cycle flag
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         req        <= '0;
         req_valid  <= 1'b0;
         status_req <= 1'b0;
         csum_error <= 1'b0;
      end else begin
         req_valid  <= 1'b0;
         status_req <= 1'b0;
         csum_error <= 1'b0;
         if (rx_valid && pst == zdofb_pkg::P_CSUM) begin
            if (psum + rx_data != zdofb_pkg::CSUM_BASE) begin
               csum_error <= 1'b1;
            end else if (papi == zdofb_pkg::API_EXPL_TX) begin
               req       <= pcap;
               req.zdo   <= (psep == 8'h00) && (pdep == 8'h00) && (pprof == 16'h0000);
               req_valid <= 1'b1;
               status_req <= (pcap.frame_id != 8'h00);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Two-entry output buffer: head and spare, both registered
   // ----------------------------------------------------------------
   logic       push;
   logic [7:0] push_data;
   logic [7:0] spare;
   logic       spare_full;
   logic       buf_ready;
   logic       pop;

   assign buf_ready = !spare_full;
   assign pop       = tx_valid && tx_ready;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_valid   <= 1'b0;
         tx_data    <= 8'h00;
         spare      <= 8'h00;
         spare_full <= 1'b0;
      end else begin
         if (!tx_valid || pop) begin
            if (spare_full) begin
               tx_data    <= spare;
               tx_valid   <= 1'b1;
               spare_full <= push;
               if (push) spare <= push_data;
            end else begin
               tx_valid <= push;
               if (push) tx_data <= push_data;
            end
         end else if (push) begin
            spare      <= push_data;
            spare_full <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Explicit receive frame builder
   // ----------------------------------------------------------------
   zdofb_pkg::zdofb_bst_e bst;
   zdofb_pkg::zdofb_rsp_s hold;
   logic [4:0]            bidx;
   logic [7:0]            bcnt;
   logic [7:0]            bsum;
   logic [15:0]           blen;
   logic [7:0]            hdr_byte;
   logic                  take_pay;

   assign blen     = zdofb_pkg::EXPL_RX_FIXED + {8'h00, hold.pay_len};
   assign take_pay = pay_valid && pay_ready;

   // Header bytes in wire order; frame fields go high byte first
   always_comb begin
      case (bidx)
         5'h00:   hdr_byte = zdofb_pkg::DELIM;
         5'h01:   hdr_byte = blen[15:8];
         5'h02:   hdr_byte = blen[7:0];
         5'h03:   hdr_byte = zdofb_pkg::API_EXPL_RX;
         5'h0C:   hdr_byte = hold.src_addr16[15:8];
         5'h0D:   hdr_byte = hold.src_addr16[7:0];
         5'h0E:   hdr_byte = hold.src_ep;
         5'h0F:   hdr_byte = hold.dst_ep;
         5'h10:   hdr_byte = hold.cluster[15:8];
         5'h11:   hdr_byte = hold.cluster[7:0];
         5'h12:   hdr_byte = hold.profile[15:8];
         5'h13:   hdr_byte = hold.profile[7:0];
         5'h14:   hdr_byte = hold.rx_opts;
         5'h15:   hdr_byte = hold.seq;
         default: hdr_byte = hold.src_addr64[{3'(5'h0B - bidx), 3'b000} +: 8];
      endcase
   end

   always_comb begin
      push      = 1'b0;
      push_data = 8'h00;
      case (bst)
         zdofb_pkg::B_HDR: begin
            push      = buf_ready;
            push_data = hdr_byte;
         end
         zdofb_pkg::B_PAY: begin
            push      = take_pay;
            push_data = pay_data;
         end
         zdofb_pkg::B_CSUM: begin
            push      = buf_ready;
            push_data = zdofb_pkg::CSUM_BASE - bsum;
         end
         default: begin
            push      = 1'b0;
            push_data = 8'h00;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         bst  <= zdofb_pkg::B_IDLE;
         hold <= '0;
         bidx <= 5'h00;
         bcnt <= 8'h00;
         bsum <= 8'h00;
      end else begin
         case (bst)
            zdofb_pkg::B_IDLE: begin
               bidx <= 5'h00;
               bsum <= 8'h00;
               // With the option off the response is consumed and withheld
               if (rsp_valid && rsp_ready && receiver_addressing_option) begin
                  hold <= rsp;
                  bst  <= zdofb_pkg::B_HDR;
               end
            end
            zdofb_pkg::B_HDR: begin
               if (push) begin
                  bidx <= bidx + 5'h01;
                  if (bidx >= zdofb_pkg::RX_POS_API) bsum <= bsum + hdr_byte;
                  if (bidx == zdofb_pkg::RX_POS_SEQ) begin
                     bcnt <= hold.pay_len;
                     bst  <= (hold.pay_len == 8'h00) ? zdofb_pkg::B_CSUM : zdofb_pkg::B_PAY;
                  end
               end
            end
            zdofb_pkg::B_PAY: begin
               if (take_pay) begin
                  bsum <= bsum + pay_data;
                  bcnt <= bcnt - 8'h01;
                  if (bcnt == 8'h01) bst <= zdofb_pkg::B_CSUM;
               end
            end
            zdofb_pkg::B_CSUM: begin
               if (push) bst <= zdofb_pkg::B_IDLE;
            end
            default: bst <= zdofb_pkg::B_IDLE;
         endcase
      end
   end

   // Handshake readies from flops; payload runs at most every other cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp_ready <= 1'b0;
         pay_ready <= 1'b0;
      end else begin
         rsp_ready <= (bst == zdofb_pkg::B_IDLE) && !(rsp_valid && rsp_ready);
         pay_ready <= (bst == zdofb_pkg::B_PAY) && !take_pay && !push && !spare_full
                      && !(take_pay && bcnt == 8'h01);
      end
   end

endmodule
